// ### logic/clkdiv_pkg.sv
/*
 * Constants and carriers shared by the channel clock divider block:
 * register offsets, field layouts, reset values and widths.
 * Assumes one clock (the divider input clock) and a synchronous reset.
 */
package clkdiv_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int CNT_W = 4;
   localparam int TIMER_W = 5;
   localparam int NUM_CH = 2;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses on the plain port)
   localparam logic [11:0] DIV2_COUNTS_ADDR = 12'h196;
   localparam logic [11:0] DIV2_CTRL_ADDR = 12'h197;
   localparam logic [11:0] CH2_POWER_ADDR = 12'h198;
   localparam logic [11:0] DIV3_COUNTS_ADDR = 12'h199;
   localparam logic [11:0] DIV3_CTRL_ADDR = 12'h19a;
   localparam logic [11:0] CH3_POWER_ADDR = 12'h19b;
   localparam logic [11:0] STATUS_ADDR = 12'h19f;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] DIV2_COUNTS_RST = 8'h11;
   localparam logic [7:0] DIV3_COUNTS_RST = 8'h00;
   localparam logic [7:0] DIV_CTRL_RST = 8'h00;
   localparam logic [7:0] CH_POWER_RST = 8'h00;

   // Channel register: only power-down [2] and DCC disable [0] exist
   localparam logic [7:0] CH_POWER_MASK = 8'h05;
   localparam int CH_PDN_BIT = 2;
   localparam int CH_DCC_BIT = 0;

   ////////////////////////////////////////////////////////////////////////
   // Field layouts
   typedef struct packed {
      logic [3:0] low;
      logic [3:0] high;
   } counts_s;

   typedef struct packed {
      logic bypass;
      logic ignore_sync;
      logic force_high;
      logic start_high;
      logic [3:0] phase;
   } div_ctrl_s;

endpackage : clkdiv_pkg

// ### logic/channel_divider.sv
/*
 * One channel divider: low/high phase counter, start level, phase offset,
 * bypass, force level and channel power-down, all on the input clock.
 * Assumes restart is a one-cycle pulse already in this clock domain.
 */
module channel_divider (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Restart pulse from the resynchronisation pin
   input wire logic restart,
   // Configuration
   input wire clkdiv_pkg::counts_s counts,
   input wire clkdiv_pkg::div_ctrl_s ctrl,
   input wire logic power_down,
   // Results
   output logic div_out,
   output logic level
);

   ////////////////////////////////////////////////////////////////////////
   clkdiv_pkg::counts_s held;
   clkdiv_pkg::counts_s next_held;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic next_level;
   logic tgl;
   logic next_tgl;
   logic next_div_out;

   always_comb begin
      next_held = held;
      next_level = level;
      next_cnt = cnt;
      next_tgl = ~tgl;
      // Reset behaves as a restart with the reset configuration
      if (srst || (restart && !ctrl.ignore_sync)) begin
         next_held = counts;
         next_level = ctrl.start_high;
         next_cnt = {1'b0, ctrl.phase} + {1'b0, ctrl.start_high ?
                    counts.high : counts.low};
      end else if (cnt == 5'h00) begin
         next_level = ~level;
         // Leaving high means entering the low phase, and the reverse
         next_cnt = {1'b0, level ? held.low : held.high};
      end else begin
         next_cnt = cnt - 5'h01;
      end
      if (srst) begin
         next_tgl = 1'b0;
         next_div_out = 1'b0;
      end else if (power_down) begin
         next_div_out = 1'b0;
      end else if (ctrl.bypass) begin
         // A flop cannot pass the clock itself; toggling is its image
         next_div_out = ~tgl;
      end else if (ctrl.ignore_sync) begin
         next_div_out = ctrl.force_high;
      end else begin
         next_div_out = next_level;
      end
   end

   always_ff @(posedge clk) begin
      held <= next_held;
      cnt <= next_cnt;
      level <= next_level;
      tgl <= next_tgl;
      div_out <= next_div_out;
   end

endmodule : channel_divider

// ### logic/clock_channels.sv
/*
 * Channel clock dividers for output groups three and four, with their
 * configuration registers on a plain address/strobe port.
 * Assumes CLK is the divider input clock and SYNC_N comes from a pin.
 */
module clock_channels (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Resynchronisation pin, active low
   input wire logic SYNC_N,
   // Register port
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [7:0] RD_DATA,
   // Group three outputs
   output logic GROUP3_OUTPUT_A,
   output logic GROUP3_OUTPUT_B,
   output logic GROUP3_OUTPUT_C,
   output logic GROUP3_OE,
   output logic GROUP3_DCC_EN,
   // Group four outputs
   output logic GROUP4_OUTPUT_A,
   output logic GROUP4_OUTPUT_B,
   output logic GROUP4_OUTPUT_C,
   output logic GROUP4_OE,
   output logic GROUP4_DCC_EN
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode, used by the write and the read paths
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] base);
      hit = (a == base);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // Resync pin: two flops, then a falling-edge detect
   logic sync_meta;
   logic sync_sample;
   logic sync_prev;
   logic next_sync_meta;
   logic next_sync_sample;
   logic next_sync_prev;
   logic restart;

   always_comb begin
      next_sync_meta = SYNC_N;
      next_sync_sample = sync_meta;
      next_sync_prev = sync_sample;
      if (SRST) begin
         next_sync_meta = 1'b1;
         next_sync_sample = 1'b1;
         next_sync_prev = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      sync_meta <= next_sync_meta;
      sync_sample <= next_sync_sample;
      sync_prev <= next_sync_prev;
   end

   // Restart on the assertion of the active-low pin
   assign restart = sync_prev && !sync_sample;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers, index 0 is channel 2, index 1 channel 3
   clkdiv_pkg::counts_s counts [clkdiv_pkg::NUM_CH];
   clkdiv_pkg::counts_s next_counts [clkdiv_pkg::NUM_CH];
   clkdiv_pkg::div_ctrl_s ctrl [clkdiv_pkg::NUM_CH];
   clkdiv_pkg::div_ctrl_s next_ctrl [clkdiv_pkg::NUM_CH];
   logic [7:0] power [clkdiv_pkg::NUM_CH];
   logic [7:0] next_power [clkdiv_pkg::NUM_CH];

   always_comb begin
      next_counts = counts;
      next_ctrl = ctrl;
      next_power = power;
      if (SRST) begin
         next_counts[0] = clkdiv_pkg::DIV2_COUNTS_RST;
         next_counts[1] = clkdiv_pkg::DIV3_COUNTS_RST;
         next_ctrl[0] = clkdiv_pkg::DIV_CTRL_RST;
         next_ctrl[1] = clkdiv_pkg::DIV_CTRL_RST;
         next_power[0] = clkdiv_pkg::CH_POWER_RST;
         next_power[1] = clkdiv_pkg::CH_POWER_RST;
      end else if (WR_EN) begin
         if (hit(ADDR, clkdiv_pkg::DIV2_COUNTS_ADDR)) begin
            next_counts[0] = WR_DATA;
         end
         if (hit(ADDR, clkdiv_pkg::DIV2_CTRL_ADDR)) begin
            next_ctrl[0] = WR_DATA;
         end
         if (hit(ADDR, clkdiv_pkg::CH2_POWER_ADDR)) begin
            next_power[0] = WR_DATA & clkdiv_pkg::CH_POWER_MASK;
         end
         if (hit(ADDR, clkdiv_pkg::DIV3_COUNTS_ADDR)) begin
            next_counts[1] = WR_DATA;
         end
         if (hit(ADDR, clkdiv_pkg::DIV3_CTRL_ADDR)) begin
            next_ctrl[1] = WR_DATA;
         end
         if (hit(ADDR, clkdiv_pkg::CH3_POWER_ADDR)) begin
            next_power[1] = WR_DATA & clkdiv_pkg::CH_POWER_MASK;
         end
      end
   end

   always_ff @(posedge CLK) begin
      counts <= next_counts;
      ctrl <= next_ctrl;
      power <= next_power;
   end

   ////////////////////////////////////////////////////////////////////////
   // Dividers
   logic div_out [clkdiv_pkg::NUM_CH];
   logic div_level [clkdiv_pkg::NUM_CH];

   generate
      for (genvar ch = 0; ch < clkdiv_pkg::NUM_CH; ch++) begin : g_ch
         channel_divider u_div (
            .clk(CLK),
            .srst(SRST),
            .restart(restart),
            .counts(counts[ch]),
            .ctrl(ctrl[ch]),
            .power_down(power[ch][clkdiv_pkg::CH_PDN_BIT]),
            .div_out(div_out[ch]),
            .level(div_level[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Output enables and duty-cycle correction status
   logic oe [clkdiv_pkg::NUM_CH];
   logic next_oe [clkdiv_pkg::NUM_CH];
   logic dcc [clkdiv_pkg::NUM_CH];
   logic next_dcc [clkdiv_pkg::NUM_CH];

   always_comb begin
      for (int i = 0; i < clkdiv_pkg::NUM_CH; i++) begin
         // Enable drops while the channel is powered down
         next_oe[i] = !power[i][clkdiv_pkg::CH_PDN_BIT];
         // Correction is on unless its disable bit is set
         next_dcc[i] = !power[i][clkdiv_pkg::CH_DCC_BIT];
         if (SRST) begin
            next_oe[i] = 1'b0;
            next_dcc[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      oe <= next_oe;
      dcc <= next_dcc;
   end

   // Three pairs of a group share one divider
   assign GROUP3_OUTPUT_A = div_out[0];
   assign GROUP3_OUTPUT_B = div_out[0];
   assign GROUP3_OUTPUT_C = div_out[0];
   assign GROUP3_OE = oe[0];
   assign GROUP3_DCC_EN = dcc[0];
   assign GROUP4_OUTPUT_A = div_out[1];
   assign GROUP4_OUTPUT_B = div_out[1];
   assign GROUP4_OUTPUT_C = div_out[1];
   assign GROUP4_OE = oe[1];
   assign GROUP4_DCC_EN = dcc[1];

   ////////////////////////////////////////////////////////////////////////
   // Read path: data stand in the cycle after the strobe only
   logic [7:0] rd_mux;
   logic [7:0] next_rd_data;

   always_comb begin
      rd_mux = 8'h00;
      if (hit(ADDR, clkdiv_pkg::DIV2_COUNTS_ADDR)) begin
         rd_mux = counts[0];
      end
      if (hit(ADDR, clkdiv_pkg::DIV2_CTRL_ADDR)) begin
         rd_mux = ctrl[0];
      end
      if (hit(ADDR, clkdiv_pkg::CH2_POWER_ADDR)) begin
         rd_mux = power[0];
      end
      if (hit(ADDR, clkdiv_pkg::DIV3_COUNTS_ADDR)) begin
         rd_mux = counts[1];
      end
      if (hit(ADDR, clkdiv_pkg::DIV3_CTRL_ADDR)) begin
         rd_mux = ctrl[1];
      end
      if (hit(ADDR, clkdiv_pkg::CH3_POWER_ADDR)) begin
         rd_mux = power[1];
      end
      // Live divider levels and output states
      if (hit(ADDR, clkdiv_pkg::STATUS_ADDR)) begin
         rd_mux = {4'h0, div_out[1], div_out[0], div_level[1],
                   div_level[0]};
      end
      next_rd_data = 8'h00;
      if (RD_EN && !SRST) begin
         next_rd_data = rd_mux;
      end
   end

   always_ff @(posedge CLK) begin
      RD_DATA <= next_rd_data;
   end

endmodule : clock_channels

// ### test/clock_channels_sva.sv
/* Checker for clock_channels, watching only its top-level ports.
   Assumes one clock CLK and the synchronous active-high SRST. */
module clock_channels_sva (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Register port
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire logic [7:0] RD_DATA,
   // Group outputs
   input wire logic GROUP3_OUTPUT_A,
   input wire logic GROUP3_OUTPUT_B,
   input wire logic GROUP3_OUTPUT_C,
   input wire logic GROUP3_OE,
   input wire logic GROUP3_DCC_EN,
   input wire logic GROUP4_OUTPUT_A,
   input wire logic GROUP4_OUTPUT_B,
   input wire logic GROUP4_OUTPUT_C,
   input wire logic GROUP4_OE,
   input wire logic GROUP4_DCC_EN
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   ////////////////////////////////////////////////////////////////////////
   a_g3_fanout: assert property (GROUP3_OUTPUT_A == GROUP3_OUTPUT_B
      && GROUP3_OUTPUT_B == GROUP3_OUTPUT_C) else $error("g3 outputs differ");
   a_g4_fanout: assert property (GROUP4_OUTPUT_A == GROUP4_OUTPUT_B
      && GROUP4_OUTPUT_B == GROUP4_OUTPUT_C) else $error("g4 outputs differ");
   a_g3_off_quiet: assert property (!GROUP3_OE |-> !GROUP3_OUTPUT_A)
      else $error("g3 toggles while off");
   a_g4_off_quiet: assert property (!GROUP4_OE |-> !GROUP4_OUTPUT_A)
      else $error("g4 toggles while off");
   a_g3_oe_write: assert property (
      WR_EN && ADDR == clkdiv_pkg::CH2_POWER_ADDR
      |-> ##2 GROUP3_OE == !$past(WR_DATA[2], 2)) else $error("g3 oe");
   a_g4_oe_write: assert property (
      WR_EN && ADDR == clkdiv_pkg::CH3_POWER_ADDR
      |-> ##2 GROUP4_OE == !$past(WR_DATA[2], 2)) else $error("g4 oe");
   a_g4_dcc_write: assert property (
      WR_EN && ADDR == clkdiv_pkg::CH3_POWER_ADDR
      |-> ##2 GROUP4_DCC_EN == !$past(WR_DATA[0], 2)) else $error("g4 dcc");
   a_g3_dcc_write: assert property (
      WR_EN && ADDR == clkdiv_pkg::CH2_POWER_ADDR
      |-> ##2 GROUP3_DCC_EN == !$past(WR_DATA[0], 2)) else $error("g3 dcc");
   a_power_reserved: assert property (
      RD_EN && ADDR == clkdiv_pkg::CH3_POWER_ADDR
      |=> (RD_DATA & ~clkdiv_pkg::CH_POWER_MASK) == 8'h00)
      else $error("reserved bits set");
   a_ctrl_readback: assert property (
      (WR_EN && ADDR == clkdiv_pkg::DIV3_CTRL_ADDR)
      ##1 !(WR_EN && ADDR == clkdiv_pkg::DIV3_CTRL_ADDR)
      ##1 (RD_EN && ADDR == clkdiv_pkg::DIV3_CTRL_ADDR)
      |=> RD_DATA == $past(WR_DATA, 3)) else $error("ctrl readback");
   cover property (WR_EN && ADDR == clkdiv_pkg::CH2_POWER_ADDR);
   cover property ($rose(GROUP4_OUTPUT_A));
   cover property (RD_EN && ADDR == clkdiv_pkg::DIV3_CTRL_ADDR);
endmodule : clock_channels_sva

bind clock_channels clock_channels_sva sva_i (.CLK(CLK), .SRST(SRST),
   .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
   .RD_DATA(RD_DATA), .GROUP3_OUTPUT_A(GROUP3_OUTPUT_A),
   .GROUP3_OUTPUT_B(GROUP3_OUTPUT_B), .GROUP3_OUTPUT_C(GROUP3_OUTPUT_C),
   .GROUP3_OE(GROUP3_OE), .GROUP3_DCC_EN(GROUP3_DCC_EN),
   .GROUP4_OUTPUT_A(GROUP4_OUTPUT_A),
   .GROUP4_OUTPUT_B(GROUP4_OUTPUT_B), .GROUP4_OUTPUT_C(GROUP4_OUTPUT_C),
   .GROUP4_OE(GROUP4_OE), .GROUP4_DCC_EN(GROUP4_DCC_EN));

// ### test/clock_channels_tb.sv
/* Self-checking bench for clock_channels: registers and waveforms.
   Assumes the design alone; inputs change by NBA at rising CLK. */
module clock_channels_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, srst, sync_n, wr_en, rd_en, oe3, dcc3, oe4, dcc4;
   logic [11:0] addr;
   logic [7:0] wr_data, rd_data;
   logic [2:0] g3, g4;
   int err_total, samples_checked, hi, lo;
   logic [11:0] raddr [7] = '{12'h196, 12'h197, 12'h198, 12'h199, 12'h19a,
      12'h19b, 12'h000};
   logic [7:0] rrst [7] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Counts, control, expected longest high and low runs
   logic [7:0] rcnt [4] = '{8'h21, 8'h00, 8'h00, 8'h00};
   // Every forced setting also sets the ignore bit
   logic [7:0] rctl [4] = '{8'h00, 8'h60, 8'h40, 8'he0};
   int rhi [4] = '{2, 16, 0, 1};
   int rlo [4] = '{3, 0, 16, 1};
   ////////////////////////////////////////////////////////////////////////
   clock_channels uut (.CLK(clk), .SRST(srst), .SYNC_N(sync_n),
      .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
      .RD_DATA(rd_data), .GROUP3_OUTPUT_A(g3[0]), .GROUP3_OUTPUT_B(g3[1]),
      .GROUP3_OUTPUT_C(g3[2]), .GROUP3_OE(oe3), .GROUP3_DCC_EN(dcc3),
      .GROUP4_OUTPUT_A(g4[0]), .GROUP4_OUTPUT_B(g4[1]),
      .GROUP4_OUTPUT_C(g4[2]), .GROUP4_OE(oe4), .GROUP4_DCC_EN(dcc4));
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'h1;
      @(posedge clk);
      wr_en <= 1'h0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge clk);
      rd_en <= 1'h0;
      #1;
      chk("read data", rd_data, exp);
   endtask : rd
   task automatic pulse_sync;
      @(posedge clk);
      sync_n <= 1'h0;
      @(posedge clk);
      sync_n <= 1'h1;
   endtask : pulse_sync
   // Longest high and low runs on output A of one group
   task automatic mrun(input bit four, input int skip, n);
      int ch, cl;
      logic v;
      hi = 0;
      lo = 0;
      ch = 0;
      cl = 0;
      repeat (skip) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         #1;
         v = four ? g4[0] : g3[0];
         ch = (v === 1'h1) ? ch + 1 : 0;
         cl = (v === 1'h0) ? cl + 1 : 0;
         hi = (ch > hi) ? ch : hi;
         lo = (cl > lo) ? cl : lo;
      end
   endtask : mrun
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // Nothing below waits open-ended; this only guards against a stall
   initial begin
      #200000;
      err_total++;
      close_out();
   end
   initial begin
      srst <= 1'h1;
      sync_n <= 1'h1;
      wr_en <= 1'h0;
      rd_en <= 1'h0;
      addr <= 12'h000;
      wr_data <= 8'h00;
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      wr(12'h000, 8'hff);
      for (int i = 0; i < 7; i++) rd(raddr[i], rrst[i]);
      chk("oe dcc", {4'h0, oe3, dcc3, oe4, dcc4}, 8'h0f);
      mrun(1'b0, 0, 16);
      chk("ch2 runs", {hi[3:0], lo[3:0]}, 8'h22);
      wr(clkdiv_pkg::CH3_POWER_ADDR, 8'hff);
      rd(clkdiv_pkg::CH3_POWER_ADDR, 8'h05);
      chk("g4 off", {1'h0, g4, oe4, dcc4, oe3, dcc3}, 8'h03);
      wr(clkdiv_pkg::CH3_POWER_ADDR, 8'h00);
      wr(clkdiv_pkg::CH2_POWER_ADDR, 8'h04);
      rd(clkdiv_pkg::CH2_POWER_ADDR, 8'h04);
      chk("g3 off", {1'h0, g3, oe3, dcc3, oe4, dcc4}, 8'h07);
      wr(clkdiv_pkg::CH2_POWER_ADDR, 8'h00);
      wr(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h05);
      rd(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h05);
      wr(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h00);
      // Count edit with no resync must leave the 1/1 waveform alone
      wr(clkdiv_pkg::DIV3_COUNTS_ADDR, 8'h33);
      mrun(1'b1, 4, 16);
      chk("no resync", {hi[3:0], lo[3:0]}, 8'h11);
      for (int i = 0; i < 4; i++) begin
         wr(clkdiv_pkg::DIV3_COUNTS_ADDR, rcnt[i]);
         wr(clkdiv_pkg::DIV3_CTRL_ADDR, rctl[i]);
         pulse_sync();
         mrun(1'b1, 16, 16);
         chk("high run", 8'(hi), 8'(rhi[i]));
         chk("low run", 8'(lo), 8'(rlo[i]));
      end
      // Ignored pulses must not have loaded the counts written beside them
      wr(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h00);
      mrun(1'b1, 4, 16);
      chk("ignored resync", {hi[3:0], lo[3:0]}, 8'h23);
      // Two cycles of slack on the high hold, one on the low: the last old-level cycle may touch the hold
      wr(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h13);
      pulse_sync();
      mrun(1'b1, 0, 24);
      chk("start high hold", {7'h0, hi inside {[4:6]}}, 8'h01);
      wr(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h05);
      pulse_sync();
      mrun(1'b1, 0, 24);
      chk("start low hold", {7'h0, lo inside {[6:7]}}, 8'h01);
      // Long start-high holds make the live status word predictable
      wr(clkdiv_pkg::DIV2_CTRL_ADDR, 8'h1f);
      wr(clkdiv_pkg::DIV3_CTRL_ADDR, 8'h1f);
      pulse_sync();
      repeat (2) @(posedge clk);
      rd(clkdiv_pkg::STATUS_ADDR, 8'h0f);
      close_out();
   end
endmodule : clock_channels_tb
